/* File: design/pcr_regs.vh */
// Register map, field positions and reset values of the loop control bank
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

`define PCR_IDX_CTRL        8'h36
`define PCR_IDX_BWC         8'h37
`define PCR_IDX_MULH        8'h38
`define PCR_IDX_MULL        8'h39
`define PCR_IDX_RANGE       8'h3A
`define PCR_IDX_STATUS      8'h3B

`define PCR_ADDR_CTRL       10'h0D8
`define PCR_ADDR_BWC        10'h0DC
`define PCR_ADDR_MULH       10'h0E0
`define PCR_ADDR_MULL       10'h0E4
`define PCR_ADDR_RANGE      10'h0E8
`define PCR_ADDR_STATUS     10'h0EC

`define PCR_CTRL_IRQ_EN     7
`define PCR_CTRL_FLAG       6
`define PCR_CTRL_PWR        5
`define PCR_CTRL_BCS        4
`define PCR_CTRL_PRE_HI     3
`define PCR_CTRL_PRE_LO     2
`define PCR_CTRL_VPR_HI     1
`define PCR_CTRL_VPR_LO     0

`define PCR_BWC_AUTO        7
`define PCR_BWC_LOCK        6
`define PCR_BWC_TRACK       5

`define PCR_RST_PWR         1'b1
`define PCR_RST_MULL        8'h40
`define PCR_RST_MULH        4'h0
`define PCR_RST_RANGE       8'h40

`define PCR_SWITCH_CYCLES   3

`define PCR_RESP_OKAY       2'h0
`define PCR_RESP_SLVERR     2'h2

`endif

/* File: design/pcr_clock_switch.v */
// Glitch-free base clock selector with hold and divide by two
`timescale 1ns/1ps
module pcr_clock_switch #(
    parameter HOLD_CYCLES = 3
) (
    // Clock and reset
    input  wire MCLK,
    input  wire RST,
    // Source tick enables and selection
    input  wire xtal_tick,
    input  wire vco_tick,
    input  wire select_vco,
    // Output
    output reg  base_clock,
    output wire switching
);
    localparam ST_RUN  = 2'h0;
    localparam ST_XOLD = 2'h1;
    localparam ST_XNEW = 2'h2;

    reg [1:0] state_reg;
    reg       cur_sel_reg;
    reg [2:0] cnt_reg;

    assign switching = (state_reg != ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Waits out old and new source ticks so the output never gets a runt edge
    always @(posedge MCLK) begin
        if (RST) begin
            state_reg   <= ST_RUN;
            cur_sel_reg <= 1'b0;
            cnt_reg     <= 3'h0;
            base_clock  <= 1'b0;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (select_vco != cur_sel_reg) begin
                        state_reg <= ST_XOLD; // [RL9]
                        cnt_reg   <= 3'h0;
                    end else if (cur_sel_reg ? vco_tick : xtal_tick) begin
                        base_clock <= ~base_clock; // [RL8]
                    end
                end
                ST_XOLD: begin
                    if (cur_sel_reg ? vco_tick : xtal_tick) begin
                        if (cnt_reg == HOLD_CYCLES[2:0] - 3'h1) begin
                            state_reg   <= ST_XNEW;
                            cnt_reg     <= 3'h0;
                            cur_sel_reg <= select_vco;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                end
                ST_XNEW: begin
                    if (cur_sel_reg ? vco_tick : xtal_tick) begin
                        if (cnt_reg == HOLD_CYCLES[2:0] - 3'h1) begin
                            state_reg <= ST_RUN;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end
endmodule

/* File: design/pcr_pll_bank.v */
// Loop control register bank with AXI4-Lite slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// [RL1] Interrupt enable forced zero in manual mode
// [RL2] Lock toggle sets flag; flag and enable interrupt
// [RL3] Control read clears flag; writes never set
// [RL4] Manual mode reads flag and lock zero
// [RL5] Select forced clear when off or range zero
// [RL6] Select set holds power on
// [RL7] Software powers on before selecting loop clock
// [RL8] Select chooses loop or crystal clock halved
// [RL9] Output held still during source switchover
// [RL10] Prescaler locked while powered, reset clears
// [RL11] Range exponent locked while powered, reset clears
// [RL12] Software never programs exponent three
// [RL13] Multiplier bits locked while powered
// [RL14] Zero multiplier behaves as one
// [RL15] Multiplier resets to sixty-four
// [RL16] High multiplier upper nibble reads zero
// [RL17] Auto bandwidth bit read/write, reset clear
// [RL18] Auto mode lock bit read-only status
// [RL19] Software writes zero to lock position
// [RL20] Tracking bit status in auto, control manual
// [RL21] Manual tracking value kept across auto mode
// [RL22] Software clears tracking before powering manual loop
// [RL23] Stop clears select; stays clear after
`include "pcr_regs.vh"
module pcr_pll_bank #(
    parameter HOLD_CYCLES = `PCR_SWITCH_CYCLES
) (
    // Clock and reset
    input  wire        MCLK,
    input  wire        RST,
    // AXI4-Lite write address
    input  wire [9:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    // AXI4-Lite write response
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire [9:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    // AXI4-Lite read data
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    // Loop status and clock sources
    input  wire        LOOP_LOCKED,
    input  wire        LOOP_TRACKING,
    input  wire        STOP_ENTRY,
    input  wire        XTAL_TICK,
    input  wire        VCO_TICK,
    // Loop control outputs
    output wire        PLL_IRQ,
    output wire        PLL_ENABLE,
    output wire        LOOP_TRACK_CMD,
    output wire        AUTO_BANDWIDTH,
    output wire [1:0]  PRESCALE,
    output wire [1:0]  RANGE_EXPONENT,
    output wire [7:0]  RANGE_MULT,
    output wire [11:0] FEEDBACK_DIV,
    output wire        BASE_CLOCK_OUT,
    output wire        SWITCHING
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg        irq_en_reg;
    reg        flag_reg;
    reg        pwr_reg;
    reg        bcs_reg;
    reg [1:0]  pre_reg;
    reg [1:0]  vpr_reg;
    reg        auto_reg;
    reg        track_man_reg;
    reg [3:0]  mulh_reg;
    reg [7:0]  mull_reg;
    reg [7:0]  range_reg;
    reg        lock_d_reg;
    reg        aw_hold_reg;
    reg        w_hold_reg;
    reg [9:0]  aw_addr_reg;
    reg [31:0] w_data_reg;
    reg        w_lane0_reg;

    wire [7:0] wbyte;
    wire       do_write;
    wire       do_read;
    wire [9:0] waddr;
    wire       wr_ctrl;
    wire       wr_bwc;
    wire       wr_mulh;
    wire       wr_mull;
    wire       wr_range;
    wire       rd_ctrl;
    wire       lock_view;
    wire       track_view;
    wire [7:0] ctrl_view;
    wire [7:0] bwc_view;
    reg  [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode shared by both channels
    function is_mapped;
        input [9:0] addr;
        begin
            is_mapped = (addr == `PCR_ADDR_CTRL) || (addr == `PCR_ADDR_BWC) ||
                        (addr == `PCR_ADDR_MULH) || (addr == `PCR_ADDR_MULL) ||
                        (addr == `PCR_ADDR_RANGE) || (addr == `PCR_ADDR_STATUS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data latched independently, either order
    assign S_AXI_AWREADY = ~aw_hold_reg & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_hold_reg & ~S_AXI_BVALID;
    assign do_write      = aw_hold_reg & w_hold_reg;
    assign waddr         = aw_addr_reg;
    assign wbyte         = w_data_reg[7:0];
    assign wr_ctrl  = do_write & w_lane0_reg & (waddr == `PCR_ADDR_CTRL);
    assign wr_bwc   = do_write & w_lane0_reg & (waddr == `PCR_ADDR_BWC);
    assign wr_mulh  = do_write & w_lane0_reg & (waddr == `PCR_ADDR_MULH);
    assign wr_mull  = do_write & w_lane0_reg & (waddr == `PCR_ADDR_MULL);
    assign wr_range = do_write & w_lane0_reg & (waddr == `PCR_ADDR_RANGE);

    always @(posedge MCLK) begin
        if (RST) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= 10'h000;
            w_data_reg   <= 32'h00000000;
            w_lane0_reg  <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `PCR_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= {S_AXI_AWADDR[9:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_reg  <= 1'b1;
                w_data_reg  <= S_AXI_WDATA;
                w_lane0_reg <= S_AXI_WSTRB[0];
            end
            if (do_write) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= is_mapped(waddr) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle to data
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign do_read       = S_AXI_ARVALID & S_AXI_ARREADY;
    assign rd_ctrl       = do_read & ({S_AXI_ARADDR[9:2], 2'b00} == `PCR_ADDR_CTRL);

    // Manual mode hides live loop status
    assign lock_view  = auto_reg & LOOP_LOCKED; // [RL4] [RL18]
    assign track_view = auto_reg ? LOOP_TRACKING : track_man_reg; // [RL20]
    assign ctrl_view  = {irq_en_reg & auto_reg, flag_reg & auto_reg, pwr_reg, bcs_reg,
                         pre_reg, vpr_reg}; // [RL1] [RL4]
    assign bwc_view   = {auto_reg, lock_view, track_view, 5'h00};

    always @* begin
        case ({S_AXI_ARADDR[9:2], 2'b00})
            `PCR_ADDR_CTRL:   rd_byte = ctrl_view;
            `PCR_ADDR_BWC:    rd_byte = bwc_view;
            `PCR_ADDR_MULH:   rd_byte = {4'h0, mulh_reg}; // [RL16]
            `PCR_ADDR_MULL:   rd_byte = mull_reg;
            `PCR_ADDR_RANGE:  rd_byte = range_reg;
            `PCR_ADDR_STATUS: rd_byte = {7'h00, SWITCHING};
            default:          rd_byte = 8'h00;
        endcase
    end

    always @(posedge MCLK) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `PCR_RESP_OKAY;
        end else if (do_read) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h000000, rd_byte};
            S_AXI_RRESP  <= is_mapped({S_AXI_ARADDR[9:2], 2'b00}) ? `PCR_RESP_OKAY
                                                                  : `PCR_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    always @(posedge MCLK) begin
        if (RST) begin
            irq_en_reg <= 1'b0;
            flag_reg   <= 1'b0;
            pwr_reg    <= `PCR_RST_PWR;
            bcs_reg    <= 1'b0;
            pre_reg    <= 2'b00; // [RL10]
            vpr_reg    <= 2'b00; // [RL11]
            lock_d_reg <= 1'b0;
        end else begin
            lock_d_reg <= LOOP_LOCKED;
            // Set beats the read clear so a toggle is never lost
            if (auto_reg && (LOOP_LOCKED != lock_d_reg)) begin
                flag_reg <= 1'b1; // [RL2]
            end else if (rd_ctrl) begin
                flag_reg <= 1'b0; // [RL3]
            end
            if (!auto_reg) begin
                irq_en_reg <= 1'b0; // [RL1]
            end else if (wr_ctrl) begin
                irq_en_reg <= wbyte[`PCR_CTRL_IRQ_EN];
            end
            if (wr_ctrl) begin
                // Power and select use pre-write values, so one write cannot do both
                if (!bcs_reg) begin
                    pwr_reg <= wbyte[`PCR_CTRL_PWR]; // [RL6] [RL7]
                end
                if (!pwr_reg) begin
                    pre_reg <= wbyte[`PCR_CTRL_PRE_HI:`PCR_CTRL_PRE_LO]; // [RL10]
                    vpr_reg <= wbyte[`PCR_CTRL_VPR_HI:`PCR_CTRL_VPR_LO]; // [RL11] [RL12]
                end
            end
            if (STOP_ENTRY || !pwr_reg || (range_reg == 8'h00)) begin
                bcs_reg <= 1'b0; // [RL5] [RL23]
            end else if (wr_ctrl) begin
                bcs_reg <= wbyte[`PCR_CTRL_BCS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bandwidth, multiplier and range registers
    always @(posedge MCLK) begin
        if (RST) begin
            auto_reg      <= 1'b0; // [RL17]
            track_man_reg <= 1'b0; // [RL20]
            mulh_reg      <= `PCR_RST_MULH; // [RL15]
            mull_reg      <= `PCR_RST_MULL; // [RL15]
            range_reg     <= `PCR_RST_RANGE;
        end else begin
            if (wr_bwc) begin
                auto_reg <= wbyte[`PCR_BWC_AUTO]; // [RL17]
                // Lock position write is a test hook and is dropped
                if (!auto_reg) begin
                    track_man_reg <= wbyte[`PCR_BWC_TRACK]; // [RL19] [RL20] [RL21] [RL22]
                end
            end
            if (!pwr_reg) begin
                if (wr_mulh) begin
                    mulh_reg <= wbyte[3:0]; // [RL13]
                end
                if (wr_mull) begin
                    mull_reg <= wbyte; // [RL13]
                end
                if (wr_range) begin
                    range_reg <= wbyte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to the analog loop
    assign PLL_IRQ        = flag_reg & irq_en_reg & auto_reg; // [RL2]
    assign PLL_ENABLE     = pwr_reg & (range_reg != 8'h00);
    assign LOOP_TRACK_CMD = track_man_reg;
    assign AUTO_BANDWIDTH = auto_reg;
    assign PRESCALE       = pre_reg;
    assign RANGE_EXPONENT = vpr_reg;
    assign RANGE_MULT     = range_reg;
    assign FEEDBACK_DIV   = ({mulh_reg, mull_reg} == 12'h000) ? 12'h001
                                                                : {mulh_reg, mull_reg}; // [RL14]

    pcr_clock_switch #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_switch (
        .MCLK       (MCLK),
        .RST        (RST),
        .xtal_tick  (XTAL_TICK),
        .vco_tick   (VCO_TICK),
        .select_vco (bcs_reg), // [RL8]
        .base_clock (BASE_CLOCK_OUT),
        .switching  (SWITCHING) // [RL9]
    );
endmodule

/* File: test/pcr_pll_bank_asserts.sv */
// Port-level checker for the loop control register bank
`timescale 1ns/1ps
module pcr_pll_bank_asserts #(
    parameter HOLD_CYCLES = 3
) (
    // Clock and reset
    input wire        MCLK,
    input wire        RST,
    // Bus handshakes
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire        S_AXI_RVALID,
    input wire        S_AXI_RREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_BREADY,
    // Loop control
    input wire        PLL_IRQ,
    input wire        PLL_ENABLE,
    input wire        AUTO_BANDWIDTH,
    input wire        LOOP_TRACK_CMD,
    input wire [1:0]  PRESCALE,
    input wire [1:0]  RANGE_EXPONENT,
    input wire [7:0]  RANGE_MULT,
    input wire [11:0] FEEDBACK_DIV,
    input wire        BASE_CLOCK_OUT,
    input wire        SWITCHING
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    irq_needs_auto_a: assert property (
        PLL_IRQ |-> AUTO_BANDWIDTH) else $error("irq raised in manual mode");
    fdiv_never_zero_a: assert property (
        FEEDBACK_DIV != 12'h000) else $error("feedback divider zero");
    // Guarded by past reset: fields jump to reset values on release
    prog_locked_a: assert property (
        !$past(RST) && $past(PLL_ENABLE) |-> $stable(PRESCALE) && $stable(RANGE_EXPONENT)
        && $stable(FEEDBACK_DIV)) else $error("programming changed while powered");
    enable_needs_range_a: assert property (
        PLL_ENABLE |-> RANGE_MULT != 8'h00) else $error("loop enabled with zero range");
    track_kept_a: assert property (
        !$past(RST) && AUTO_BANDWIDTH && $past(AUTO_BANDWIDTH) |-> $stable(LOOP_TRACK_CMD))
        else $error("manual tracking changed in auto mode");
    switch_freeze_a: assert property (
        SWITCHING ##1 SWITCHING |-> $stable(BASE_CLOCK_OUT)) else $error("edge during switch");
    read_answer_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read not answered");
    rdata_hold_a: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    bresp_hold_a: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("write response dropped");
    cover property (PLL_IRQ);
    cover property ($fell(SWITCHING));
    cover property (S_AXI_RVALID && !S_AXI_RREADY);
endmodule
bind pcr_pll_bank pcr_pll_bank_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

/* File: test/tb.sv */
// Self-checking bench of the loop control register bank
`timescale 1ns/1ps
`include "pcr_regs.vh"
`define CHK(n, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("Error %s expected %h seen %h", n, e, g); \
    end \
end
module tb;
    localparam [9:0] ctl = `PCR_ADDR_CTRL, bwc = `PCR_ADDR_BWC, rg = `PCR_ADDR_RANGE;
    localparam [9:0] mh  = `PCR_ADDR_MULH, ml = `PCR_ADDR_MULL;
    reg        MCLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    reg        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, STOP_ENTRY = 0, XTAL_TICK = 0, VCO_TICK = 0;
    reg        LOOP_LOCKED = 0, LOOP_TRACKING = 0, xt_en = 1, vt_en = 1;
    reg [9:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    reg [31:0] S_AXI_WDATA = 0;
    reg [3:0]  S_AXI_WSTRB = 4'hF;
    reg [7:0]  rd;
    wire       S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID, S_AXI_RVALID, PLL_IRQ;
    wire       PLL_ENABLE, LOOP_TRACK_CMD, AUTO_BANDWIDTH, BASE_CLOCK_OUT, SWITCHING;
    wire [1:0] S_AXI_BRESP, S_AXI_RRESP, PRESCALE, RANGE_EXPONENT;
    wire [31:0] S_AXI_RDATA;
    wire [7:0] RANGE_MULT;
    wire [11:0] FEEDBACK_DIV;
    integer    seed = 32'h8A42, bad_count = 0, checks_done = 0, cyc = 0, i, n;
    pcr_pll_bank #(.HOLD_CYCLES(3)) uut (.*);
    ////////////////////////////////////////////////////////////////////////////////
    always #10 MCLK = ~MCLK;
    // Ticks at unequal rates so the two sources are told apart
    always @(posedge MCLK) begin
        XTAL_TICK <= xt_en & cyc[0];
        VCO_TICK <= vt_en & (cyc % 3 == 0);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim;
        end
    end
    task end_sim;
        begin
            $display("checks %0d errors %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    function [11:0] fdiv(input [11:0] m);
        fdiv = (m == 12'h000) ? 12'h001 : m;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Ready is sampled before the edge's updates land, as the slave sees it
    task axw(input [9:0] a, input [7:0] d, input [1:0] er);
        reg got;
        begin
            got = 0;
            @(posedge MCLK);
            S_AXI_AWADDR <= a;
            S_AXI_WDATA <= {24'h0, d};
            S_AXI_AWVALID <= 1'b1;
            S_AXI_WVALID <= 1'b1;
            S_AXI_BREADY <= $random(seed) % 2;
            while (!got) begin
                @(posedge MCLK);
                if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
                if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    got = 1;
                    S_AXI_BREADY <= 1'b0;
                    `CHK("bresp", er, S_AXI_BRESP)
                end else S_AXI_BREADY <= 1'b1;
            end
        end
    endtask
    task axr(input [9:0] a, input [1:0] er, output [7:0] d);
        reg got;
        begin
            got = 0;
            @(posedge MCLK);
            S_AXI_ARADDR <= a;
            S_AXI_ARVALID <= 1'b1;
            S_AXI_RREADY <= $random(seed) % 2;
            while (!got) begin
                @(posedge MCLK);
                if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
                if (S_AXI_RVALID && S_AXI_RREADY) begin
                    got = 1;
                    d = S_AXI_RDATA[7:0];
                    S_AXI_RREADY <= 1'b0;
                    `CHK("rresp", er, S_AXI_RRESP)
                end else S_AXI_RREADY <= 1'b1;
            end
        end
    endtask
    task wr(input [9:0] a, input [7:0] d);
        axw(a, d, `PCR_RESP_OKAY);
    endtask
    task chk_rd(input [9:0] a, input [7:0] e);
        begin
            axr(a, `PCR_RESP_OKAY, rd);
            `CHK("register", e, rd)
        end
    endtask
    // Counts output edges with only one source ticking
    task route(input s);
        integer c;
        reg     last;
        begin
            repeat (2) @(posedge MCLK);
            for (i = 0; i < 300 && SWITCHING !== 1'b0; i++) @(posedge MCLK);
            `CHK("switch done", 1'b0, SWITCHING)
            for (n = 0; n < 2; n++) begin
                xt_en <= (n == 0) ? !s : s;
                vt_en <= (n == 0) ? s : !s;
                c = 0;
                repeat (3) @(posedge MCLK);
                last = BASE_CLOCK_OUT;
                repeat (40) begin
                    @(posedge MCLK);
                    if (BASE_CLOCK_OUT !== last) c++;
                    last = BASE_CLOCK_OUT;
                end
                `CHK("routed edges", n == 0, c > 0)
            end
            xt_en <= 1'b1;
            vt_en <= 1'b1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge MCLK);
        RST <= 1'b0;
        chk_rd(ctl, 8'h20);
        chk_rd(bwc, 8'h00);
        chk_rd(mh, 8'h00);
        chk_rd(ml, 8'h40);
        axr(10'h100, `PCR_RESP_SLVERR, rd);
        axw(10'h100, 8'hFF, `PCR_RESP_SLVERR);
        wr(ml, 8'h12);
        chk_rd(ml, 8'h40);
        wr(ctl, 8'h0E);
        chk_rd(ctl, 8'h00);
        wr(ctl, 8'h0E);
        chk_rd(ctl, 8'h0E);
        `CHK("prescale", 2'h3, PRESCALE)
        for (i = 0; i < 6; i++) begin
            n = (i == 0) ? 0 : $random(seed);
            wr(mh, n[15:8]);
            wr(ml, n[7:0]);
            chk_rd(mh, {4'h0, n[11:8]});
            `CHK("fdiv", fdiv(n[11:0]), FEEDBACK_DIV)
        end
        wr(ctl, 8'h3E);
        chk_rd(ctl, 8'h2E);
        wr(ctl, 8'h3E);
        chk_rd(ctl, 8'h3E);
        wr(ctl, 8'h1E);
        chk_rd(ctl, 8'h3E);
        route(1'b1);
        STOP_ENTRY <= 1'b1;
        @(posedge MCLK);
        STOP_ENTRY <= 1'b0;
        chk_rd(ctl, 8'h2E);
        route(1'b0);
        wr(ctl, 8'h0E);
        wr(rg, 8'h00);
        wr(ctl, 8'h2E);
        `CHK("enable", 1'b0, PLL_ENABLE)
        wr(ctl, 8'h3E);
        chk_rd(ctl, 8'h2E);
        wr(ctl, 8'hAE);
        chk_rd(ctl, 8'h2E);
        LOOP_LOCKED <= 1'b1;
        repeat (4) @(posedge MCLK);
        chk_rd(bwc, 8'h00);
        wr(bwc, 8'h20);
        `CHK("track cmd", 1'b1, LOOP_TRACK_CMD)
        wr(bwc, 8'hA0);
        chk_rd(bwc, 8'hC0);
        wr(ctl, 8'hAE);
        chk_rd(ctl, 8'hAE);
        LOOP_LOCKED <= 1'b0;
        repeat (4) @(posedge MCLK);
        `CHK("irq", 1'b1, PLL_IRQ)
        chk_rd(ctl, 8'hEE);
        `CHK("irq", 1'b0, PLL_IRQ)
        wr(ctl, 8'hEE);
        chk_rd(ctl, 8'hAE);
        wr(bwc, 8'h80);
        chk_rd(bwc, 8'h80);
        LOOP_LOCKED <= 1'b1;
        wr(bwc, 8'h00);
        chk_rd(bwc, 8'h20);
        chk_rd(ctl, 8'h2E);
        end_sim;
    end
endmodule
